// >>> inc/mfpt_pkg.sv
// Summary of operation
// - 16-bit up-counter, software clearable and readable, counts prescaler or event input
// - Period and compare registers are directly readable and writable while buffering is off
// - With buffering on, buffers load into active registers on every counter reset
// - Software selects direct or buffered writes for period and compare
// - Counter equal to period or compare raises that comparator's match
// - Positive and complementary negative outputs come from the match signals
// - Period data sets output period, compare data sets duty ratio
// - Protection forces both outputs to the initial level
// - Protection comes from the protect pin and the converter out-of-range flag
// - Compare match and period match each raise an interrupt request
// - Period match is offered as converter start trigger
// - Runs on system clock, count clock from embedded prescaler
// - Gate enable cleared stops counting and blocks control register access
// - Sleep stops the timer
// - Timer pins are inactive until the pin function select assigns them
// - Period match clears counter, counting then continues from zero
// - Run bit one counts, zero holds the counter value
// - Three-bit prescale field selects divide-by-1 to divide-by-128, default zero
// - Source select one picks event clock, zero the prescaler, default zero
`default_nettype none
package mfpt_pkg;
  localparam int CNT_W = 16;
  localparam int IDX_W = 15;
  // ==========================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_COUNT = 15'h5200;
  localparam logic [IDX_W-1:0] IDX_PERIOD = 15'h5202;
  localparam logic [IDX_W-1:0] IDX_COMPARE = 15'h5204;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 15'h5206;
  localparam logic [IDX_W-1:0] IDX_MISC = 15'h5208;
  // ==========================================
  // Control register fields
  localparam int CTL_RUN = 0;
  localparam int CTL_CLR = 1;
  localparam int CTL_SRC = 5;
  localparam int CTL_BUF = 7;
  localparam int CTL_PS_LO = 8;
  localparam int CTL_PSON = 11;
  // ==========================================
  // Misc register fields
  localparam int MISC_GATE = 0;
  localparam int MISC_INIT = 1;
  localparam int MISC_PINSEL = 2;
  // ==========================================
  // Reset values and word transfer size
  localparam logic [CNT_W-1:0] DATA_RST = 16'h0000;
  localparam logic [2:0] PS_RST = 3'h0;
  localparam logic GATE_RST = 1'b1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ = 3'b100
  } mfpt_bus_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } mfpt_pins_t;

  typedef struct packed {
    logic cmp_irq;
    logic prd_irq;
    logic adc_trig;
  } mfpt_evt_t;

  typedef struct packed {
    mfpt_bus_t bus;
    logic [IDX_W-1:0] idx;
    logic [31:0] hrdata;
    logic hready;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period_value_field;
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] prd_buf;
    logic [CNT_W-1:0] cmp_buf;
    logic run;
    logic src;
    logic bufen;
    logic [2:0] ps;
    logic pson;
    logic gate;
    logic init;
    logic pinsel;
    logic level;
    logic [2:0] ev_s;
    logic ev_st;
    logic [2:0] pr_s;
    logic pr_st;
    mfpt_pins_t pins;
    mfpt_evt_t evt;
  } mfpt_state_t;
endpackage : mfpt_pkg
`default_nettype wire

// >>> verilog/mfpt_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module mfpt_prescaler
#(
  parameter int DIV_W = 7
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic enable,
  input wire logic [2:0] ratio,
  // Count clock pulse
  output logic tick
);
  import mfpt_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } mfpt_psc_st_t;

  mfpt_psc_st_t q;
  mfpt_psc_st_t d;
  logic [DIV_W-1:0] mask;

  // Divide by two to the power of ratio
  always_comb
  begin
    d = q;
    mask = ~({DIV_W{1'b1}} << ratio);
    d.tick = 1'b0;
    if (enable)
    begin
      d.cnt = q.cnt + 1'b1;
      d.tick = (q.cnt & mask) == mask;
    end
    else
    begin
      d.cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule : mfpt_prescaler
`default_nettype wire

// >>> verilog/mfpt_timer.sv
`timescale 1ns/100ps
`default_nettype none
module mfpt_timer
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System
  input wire logic sleep_mode,
  input wire logic adc_out_of_range,
  // Pins
  input wire logic event_clock_input,
  input wire logic output_protect_input,
  output mfpt_pkg::mfpt_pins_t pins,
  // Events
  output mfpt_pkg::mfpt_evt_t events
);
  import mfpt_pkg::*;

  mfpt_state_t q;
  mfpt_state_t d;
  logic active;
  logic psc_tick;
  logic ev_rise;
  logic tick;
  logic wr;
  logic reload;
  logic protect;
  logic prd_hit;
  logic cmp_hit;

  // ==========================================================
  // Register read mux
  function automatic logic [CNT_W-1:0] rd_reg(input mfpt_state_t s);
    logic [CNT_W-1:0] v;
    v = '0;
    if (s.idx == IDX_MISC)
    begin
      v[MISC_GATE] = s.gate;
      v[MISC_INIT] = s.init;
      v[MISC_PINSEL] = s.pinsel;
    end
    else if (s.gate)
    begin
      case (s.idx)
        IDX_COUNT: v = s.cnt;
        IDX_PERIOD: v = s.bufen ? s.prd_buf : s.period_value_field;
        IDX_COMPARE: v = s.bufen ? s.cmp_buf : s.cmp;
        IDX_CONTROL:
        begin
          v[CTL_RUN] = s.run;
          v[CTL_SRC] = s.src;
          v[CTL_BUF] = s.bufen;
          v[CTL_PS_LO+:3] = s.ps;
          v[CTL_PSON] = s.pson;
        end
        default: v = '0;
      endcase
    end
    return v;
  endfunction : rd_reg

  // ==========================================================
  // Prescaler
  mfpt_prescaler #(
    .DIV_W(7)
  ) u_psc (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(q.pson & q.run & active & ~q.src),
    .ratio(q.ps),
    .tick(psc_tick)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    d.evt = '0;
    d.hrdata = '0;
    reload = 1'b0;
    active = q.gate & ~sleep_mode;
    // Pin synchronisers
    d.ev_s = {q.ev_s[1:0], event_clock_input};
    d.pr_s = {q.pr_s[1:0], output_protect_input};
    if (q.ev_s[1] == q.ev_s[2])
    begin
      d.ev_st = q.ev_s[2];
    end
    if (q.pr_s[1] == q.pr_s[2])
    begin
      d.pr_st = q.pr_s[2];
    end
    ev_rise = (q.ev_s[1] == q.ev_s[2]) & q.ev_s[2] & ~q.ev_st & q.pinsel;
    // Count clock
    tick = active & q.run & (q.src ? ev_rise : psc_tick);
    prd_hit = tick & (q.cnt == q.period_value_field);
    cmp_hit = tick & (q.cnt == q.cmp);
    if (tick)
    begin
      if (prd_hit)
      begin
        d.cnt = '0;
        reload = 1'b1;
        d.level = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt + 1'b1;
      end
    end
    if (cmp_hit)
    begin
      d.level = 1'b0;
    end
    d.evt.prd_irq = prd_hit;
    d.evt.cmp_irq = cmp_hit;
    d.evt.adc_trig = prd_hit;
    // Register writes, data phase
    wr = (q.bus == BUS_WRITE);
    if (wr && q.idx == IDX_MISC)
    begin
      d.gate = hwdata[MISC_GATE];
      d.init = hwdata[MISC_INIT];
      d.pinsel = hwdata[MISC_PINSEL];
    end
    else if (wr && q.gate)
    begin
      case (q.idx)
        IDX_COUNT: d.cnt = hwdata[CNT_W-1:0];
        IDX_PERIOD:
        begin
          if (q.bufen)
          begin
            d.prd_buf = hwdata[CNT_W-1:0];
          end
          else
          begin
            d.period_value_field = hwdata[CNT_W-1:0];
          end
        end
        IDX_COMPARE:
        begin
          if (q.bufen)
          begin
            d.cmp_buf = hwdata[CNT_W-1:0];
          end
          else
          begin
            d.cmp = hwdata[CNT_W-1:0];
          end
        end
        IDX_CONTROL:
        begin
          d.run = hwdata[CTL_RUN];
          d.src = hwdata[CTL_SRC];
          d.bufen = hwdata[CTL_BUF];
          d.ps = hwdata[CTL_PS_LO+:3];
          d.pson = hwdata[CTL_PSON];
          if (hwdata[CTL_CLR])
          begin
            d.cnt = '0;
            reload = 1'b1;
          end
        end
        default:
        begin
          d.cnt = d.cnt;
        end
      endcase
    end
    if (reload && q.bufen)
    begin
      d.period_value_field = q.prd_buf;
      d.cmp = q.cmp_buf;
    end
    // Bus address phase
    d.bus = BUS_IDLE;
    d.hready = 1'b1;
    if (hsel && hready && htrans[1])
    begin
      d.idx = haddr[IDX_W+1:2];
      if (hwrite && hsize == HSIZE_WORD)
      begin
        d.bus = BUS_WRITE;
      end
      else if (!hwrite)
      begin
        d.bus = BUS_READ;
        d.hrdata = {16'h0000, rd_reg(d)};
      end
    end
    // Outputs
    protect = (q.pr_st & q.pinsel) | adc_out_of_range;
    if (!q.pinsel)
    begin
      d.pins = '0;
    end
    else if (protect || !q.run || !active)
    begin
      d.pins.pos = q.init;
      d.pins.neg = q.init;
    end
    else
    begin
      d.pins.pos = q.level;
      d.pins.neg = ~q.level;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.bus <= BUS_IDLE;
      q.hready <= 1'b1;
      q.gate <= GATE_RST;
      q.ps <= PS_RST;
      q.period_value_field <= DATA_RST;
      q.cmp <= DATA_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign pins = q.pins;
  assign events = q.evt;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  clear_resets_a: assert property (
    wr && q.gate && q.idx == IDX_CONTROL && hwdata[CTL_CLR] |=> q.cnt == 16'h0000)
    else $error("counter not cleared by software");
  period_wrap_a: assert property (
    prd_hit && !wr |=> q.cnt == 16'h0000 && events.prd_irq)
    else $error("period match did not wrap counter");
  compare_irq_a: assert property (
    cmp_hit |=> events.cmp_irq ##1 events.cmp_irq == $past(cmp_hit))
    else $error("compare match interrupt missing");
  adc_trig_a: assert property (
    events.adc_trig == events.prd_irq)
    else $error("converter trigger differs from period match");
  protect_out_a: assert property (
    protect && q.pinsel |=> pins.pos == $past(q.init) && pins.neg == $past(q.init))
    else $error("outputs not forced under protection");
  halt_hold_a: assert property (
    (!q.run || !active) && !wr |=> $stable(q.cnt))
    else $error("counter moved while halted");
  pin_select_a: assert property (
    !q.pinsel |=> !pins.pos && !pins.neg)
    else $error("outputs active without pin select");
  buffer_load_a: assert property (
    prd_hit && q.bufen && !wr |=> q.period_value_field == $past(q.prd_buf) && q.cmp == $past(q.cmp_buf))
    else $error("buffers not loaded on wrap");
  event_count_a: assert property (
    q.src && q.run && active && ev_rise && !wr && !prd_hit |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("event edge not counted");

  period_write_a: assert property (
    wr && q.gate && q.idx == IDX_PERIOD && !q.bufen |=> q.period_value_field == $past(hwdata[CNT_W-1:0]))
    else $error("direct period write lost");
  outputs_paired_a: assert property (
    q.pinsel && !protect && q.run && active |=> pins.neg == !pins.pos)
    else $error("outputs not complementary");
  gate_block_a: assert property (
    wr && !q.gate && q.idx == IDX_CONTROL |=> $stable(q.run) && $stable(q.bufen))
    else $error("control written while clock gated");
  sleep_quiet_a: assert property (
    !active |=> !events.prd_irq && !events.cmp_irq)
    else $error("match event while timer stopped");
  event_once_a: assert property (
    ev_rise |=> !ev_rise)
    else $error("event edge detected twice");
  read_idle_a: assert property (
    q.bus != BUS_READ |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  // ==========================================================
  // Scenario coverage
  wrap_seen_c: cover property (prd_hit ##[1:50] prd_hit);
  protect_seen_c: cover property (protect && q.pinsel && q.run);
  buffered_c: cover property (prd_hit && q.bufen);
  event_seen_c: cover property (ev_rise && q.src && q.run);
  sleep_seen_c: cover property (sleep_mode && q.run);
endmodule : mfpt_timer
`default_nettype wire

// >>> verification/mfpt_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module mfpt_load_model
(
  // Clock
  input wire logic hclk,
  // Timer outputs seen by the power stage
  input wire mfpt_pkg::mfpt_pins_t pins,
  // Lines back into the timer
  output logic event_pin,
  output logic fault_pin
);
  import mfpt_pkg::*;
  // ==========================================
  // Idle levels
  initial {event_pin, fault_pin} = 2'b00;
  // ==========================================
  // Event source, pulses three cycles high and low
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      event_pin <= 1'b1;
      repeat (3) @(posedge hclk);
      event_pin <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask : pulse
  // ==========================================
  // Power stage fault line
  task automatic set_fault(input logic f);
    @(posedge hclk);
    fault_pin <= f;
  endtask : set_fault
endmodule : mfpt_load_model
`default_nettype wire

// >>> verification/test_multi_function_pwm_timer.sv
`timescale 1ns/100ps
`default_nettype none
module test_multi_function_pwm_timer;
  import mfpt_pkg::*;
  localparam logic [31:0] A_CNT = 32'h0001_4800;
  localparam logic [31:0] A_PRD = 32'h0001_4808;
  localparam logic [31:0] A_CMP = 32'h0001_4810;
  localparam logic [31:0] A_CTL = 32'h0001_4818;
  localparam logic [31:0] A_MSC = 32'h0001_4820;
  logic hclk, hresetn, hsel, hwrite, sleep_mode, adc_out_of_range;
  logic hreadyout, hresp, event_pin, fault_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  mfpt_pins_t pins;
  mfpt_evt_t events;
  int miscompares, total_checks, np, nc, nh;
  // ==========================================
  // Design and power stage
  mfpt_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleep_mode(sleep_mode), .adc_out_of_range(adc_out_of_range),
    .event_clock_input(event_pin), .output_protect_input(fault_pin),
    .pins(pins), .events(events));
  mfpt_load_model u_load (.hclk(hclk), .pins(pins), .event_pin(event_pin),
    .fault_pin(fault_pin));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ==========================================
  // Checking and bus tasks
  task automatic close_out;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      close_out();
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  // Counts match pulses and high output cycles over a window
  task automatic win(input int n);
    np = 0;
    nc = 0;
    nh = 0;
    repeat (n)
    begin
      @(posedge hclk);
      np += events.prd_irq;
      nc += events.cmp_irq;
      nh += pins.pos;
      chk({31'h0, events.adc_trig}, {31'h0, events.prd_irq});
      chk({31'h0, pins.neg}, {31'h0, ~pins.pos});
    end
  endtask : win
  // ==========================================
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, sleep_mode, adc_out_of_range, htrans, hsize} = '0;
    {haddr, hwdata, miscompares, total_checks} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, hresp}, 32'h0);
    rchk(A_CNT, 32'h0);
    rchk(A_PRD, 32'h0);
    rchk(A_CMP, 32'h0);
    rchk(A_CTL, 32'h0);
    rchk(A_MSC, 32'h1);
    rchk(32'h0001_4824, 32'h0);
    xfer(1'b1, A_MSC, 32'h5);
    xfer(1'b1, A_PRD, 32'h3);
    xfer(1'b1, A_CMP, 32'h1);
    rchk(A_PRD, 32'h3);
    rchk(A_CMP, 32'h1);
    for (int r = 0; r < 3; r++)
    begin
      xfer(1'b1, A_CTL, 32'h0803 | (r << 8));
      rchk(A_CTL, 32'h0801 | (r << 8));
      repeat (8) @(posedge hclk);
      win(32);
      chk(np, 8 >> r);
      chk(nc, 8 >> r);
      chk(nh, 16);
    end
    xfer(1'b1, A_MSC, 32'h7);
    u_load.set_fault(1'b1);
    repeat (6) @(posedge hclk);
    chk({30'h0, pins}, 32'h3);
    u_load.set_fault(1'b0);
    repeat (6) @(posedge hclk);
    chk({31'h0, pins.neg}, {31'h0, ~pins.pos});
    adc_out_of_range <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({30'h0, pins}, 32'h3);
    adc_out_of_range <= 1'b0;
    xfer(1'b1, A_CTL, 32'h0800);
    xfer(1'b1, A_CNT, 32'h2);
    repeat (10) @(posedge hclk);
    rchk(A_CNT, 32'h2);
    xfer(1'b1, A_CTL, 32'h0880);
    xfer(1'b1, A_PRD, 32'h7);
    rchk(A_PRD, 32'h7);
    xfer(1'b1, A_CTL, 32'h0800);
    rchk(A_PRD, 32'h3);
    xfer(1'b1, A_CTL, 32'h0880);
    xfer(1'b1, A_CTL, 32'h0882);
    xfer(1'b1, A_CTL, 32'h0800);
    rchk(A_PRD, 32'h7);
    rchk(A_CMP, 32'h0);
    xfer(1'b1, A_CTL, 32'h0020);
    xfer(1'b1, A_CNT, 32'h0);
    xfer(1'b1, A_CTL, 32'h0021);
    u_load.pulse(5);
    repeat (6) @(posedge hclk);
    xfer(1'b1, A_CTL, 32'h0020);
    rchk(A_CNT, 32'h5);
    sleep_mode <= 1'b1;
    xfer(1'b1, A_CTL, 32'h0801);
    xfer(1'b1, A_CNT, 32'h1);
    repeat (10) @(posedge hclk);
    rchk(A_CNT, 32'h1);
    sleep_mode <= 1'b0;
    xfer(1'b1, A_MSC, 32'h4);
    xfer(1'b1, A_CTL, 32'h0);
    rchk(A_CTL, 32'h0);
    rchk(A_MSC, 32'h4);
    close_out();
  end
endmodule : test_multi_function_pwm_timer
`default_nettype wire
